// [src/host_port_regs.vh]
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH

// ----------------------------------------------------------------------
// Address decode on the four highest processor address lines
// ----------------------------------------------------------------------
`define HP_HOST_REGION     4'hf
`define HP_AUX_IO_REGION   4'h8
`define HP_EXT_MEM_REGION  4'h0
`define HP_BOOT_REGION     4'h4

// ----------------------------------------------------------------------
// Host window and handshake location
// ----------------------------------------------------------------------
`define HP_WINDOW_LO       24'hfff000
`define HP_WINDOW_HI       24'hffffff
`define HP_DATA_LOC        24'hfff000

// ----------------------------------------------------------------------
// Transfer framing
// ----------------------------------------------------------------------
`define HP_BYTE_W          8
`define HP_NIBBLE_W        4
`define HP_LANE_LAST       2'd3
`define HP_BOOT_LANE_LAST  2'd1
`define HP_FIFO_DEPTH      4
`define HP_FIFO_AW         2
`define HP_SYNC_W          15

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define HP_READY_N_RST     1'b0
`define HP_ACK_N_RST       1'b1
`define HP_PROC_RESET_RST  1'b0

`endif

// [src/byte_fifo.v]
`timescale 1ns/1ns
`default_nettype none

module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clk,
   input  wire             sys_rst,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   localparam [31:0]   DEPTH_W    = DEPTH;
   localparam [31:0]   LAST_W     = DEPTH - 1;
   localparam [AW:0]   FULL_COUNT = DEPTH_W[AW:0];
   localparam [AW-1:0] LAST_SLOT  = LAST_W[AW-1:0];

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            push;
   wire            pop;

   assign in_ready  = (count != FULL_COUNT);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == LAST_SLOT) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == LAST_SLOT) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// [src/printer_port_host_handshake.v]
// Functional notes
// - Decode bus strobe with address lines A23-A20.
// - Host port window spans 0xFFF000 to 0xFFFFFF.
// - Five decode outputs plus ready, irq, enable.
// - Disconnect input floats interrupt and ready outputs.
// - LED led_select_a reuses I/O and boot selects.
// - Falling host strobe pulses attention interrupt.
// - Pending window read asserts ack, stalls ready.
// - Strobe rising edge releases the stalled read.
// - Four bytes per word, least significant first.
// - Pending window write asserts ack, stalls ready.
// - Strobe rising edge ends the pending write.
// - Byte both ways, or nibble toward host.
// - Boot after host init skips bytes three and four, first word.
`timescale 1ns/1ns
`default_nettype none
`include "host_port_regs.vh"

module printer_port_host_handshake #(
   parameter FIFO_DEPTH = `HP_FIFO_DEPTH,
   parameter FIFO_AW    = `HP_FIFO_AW
) (
   input  wire                    clk,
   input  wire                    sys_rst,
   input  wire                    proc_strobe_n,
   input  wire                    proc_rw,
   input  wire [3:0]              proc_addr_hi,
   input  wire [`HP_BYTE_W-1:0]   proc_wdata,
   output reg  [`HP_BYTE_W-1:0]   proc_rdata,
   output reg                     proc_ready_n,
   output reg                     proc_ready_oe,
   output reg                     host_attention_irq,
   output reg                     host_attention_irq_oe,
   output reg                     proc_reset_n,
   output reg  [1:0]              byte_lane,
   output reg                     aux_read_select,
   output reg                     aux_write_select,
   output reg                     aux_io_select,
   output reg                     ext_mem_select,
   output reg                     boot_select,
   output reg                     xcvr_enable_n,
   input  wire                    host_byte_strobe_n,
   input  wire                    host_init_n,
   input  wire [`HP_BYTE_W-1:0]   host_data_in,
   output reg  [`HP_BYTE_W-1:0]   host_data_out,
   output reg                     host_data_oe,
   output reg  [`HP_NIBBLE_W-1:0] host_nibble_out,
   output reg                     host_handshake_ack_n,
   input  wire                    tri_disconnect,
   input  wire                    bidir_mode,
   input  wire                    led_select_a,
   input  wire [1:0]              led_color
);

   // ----------------------------------------------------------------------
   // Handshake states
   // ----------------------------------------------------------------------
   localparam [4:0] ST_IDLE    = 5'h01;
   localparam [4:0] ST_RD_WAIT = 5'h02;
   localparam [4:0] ST_WR_WAIT = 5'h04;
   localparam [4:0] ST_FINISH  = 5'h08;
   localparam [4:0] ST_RELEASE = 5'h10;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   reg  [`HP_SYNC_W-1:0] pin_meta;
   reg  [`HP_SYNC_W-1:0] pin_sync;
   reg                   strobe_prev;
   wire                  strobe_s;
   wire                  init_s;
   wire                  tri_s;
   wire                  bidir_s;
   wire                  led_sel_s;
   wire [1:0]            led_color_s;
   wire [`HP_BYTE_W-1:0] host_data_s;
   wire                  strobe_rise;
   wire                  strobe_fall;

   // Pins reset to their idle levels, strobe and init high and all else
   // low, so that no false edge or indicator flash follows reset.
   localparam [`HP_SYNC_W-1:0] SYNC_IDLE = {2'b11, {(`HP_SYNC_W-2){1'b0}}};

   always @(posedge clk) begin
      if (sys_rst) begin
         pin_meta    <= SYNC_IDLE;
         pin_sync    <= SYNC_IDLE;
         strobe_prev <= 1'b1;
      end else begin
         // Only the second stage is ever read by logic.
         pin_meta    <= {host_byte_strobe_n, host_init_n, tri_disconnect,
                         bidir_mode, led_select_a, led_color,
                         host_data_in};
         pin_sync    <= pin_meta;
         strobe_prev <= strobe_s;
      end
   end

   assign strobe_s    = pin_sync[14];
   assign init_s      = pin_sync[13];
   assign tri_s       = pin_sync[12];
   assign bidir_s     = pin_sync[11];
   assign led_sel_s   = pin_sync[10];
   assign led_color_s = pin_sync[9:8];
   assign host_data_s = pin_sync[7:0];
   assign strobe_rise = strobe_s && !strobe_prev;
   assign strobe_fall = !strobe_s && strobe_prev;

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   function region_hit;
      input       strobe_n;
      input [3:0] addr_hi;
      input [3:0] region;
      begin
         region_hit = !strobe_n && (addr_hi == region);
      end
   endfunction

   wire host_hit;
   wire io_hit;
   wire mem_hit;
   wire boot_hit;

   // The whole top region maps onto the host port, so every location
   // from the handshake address to the end of the window hits it.
   assign host_hit = region_hit(proc_strobe_n, proc_addr_hi,
                                `HP_HOST_REGION);
   assign io_hit   = region_hit(proc_strobe_n, proc_addr_hi,
                                `HP_AUX_IO_REGION);
   assign mem_hit  = region_hit(proc_strobe_n, proc_addr_hi,
                                `HP_EXT_MEM_REGION);
   assign boot_hit = region_hit(proc_strobe_n, proc_addr_hi,
                                `HP_BOOT_REGION);

   always @(posedge clk) begin
      if (sys_rst) begin
         aux_read_select  <= 1'b0;
         aux_write_select <= 1'b0;
         aux_io_select    <= 1'b0;
         ext_mem_select   <= 1'b0;
         boot_select      <= 1'b0;
      end else begin
         aux_read_select  <= io_hit && proc_rw;
         aux_write_select <= io_hit && !proc_rw;
         ext_mem_select   <= mem_hit;
         if (led_sel_s) begin
            aux_io_select <= led_color_s[0];
            boot_select   <= led_color_s[1];
         end else begin
            aux_io_select <= io_hit;
            boot_select   <= boot_hit;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Receive buffer between host strobe and processor reads
   // ----------------------------------------------------------------------
   reg  [4:0]            state;
   reg  [4:0]            next_state;
   wire                  fifo_in_valid;
   wire                  fifo_in_ready;
   wire                  fifo_out_valid;
   wire                  fifo_out_ready;
   wire [`HP_BYTE_W-1:0] fifo_out_data;

   // A full buffer withholds the ack, so the host keeps its strobe low.
   assign fifo_in_valid  = strobe_rise && (state == ST_RD_WAIT)
                           && !host_handshake_ack_n;
   assign fifo_out_ready = (state == ST_RD_WAIT);

   byte_fifo #(
      .WIDTH (`HP_BYTE_W),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_rx_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (host_data_s),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // ----------------------------------------------------------------------
   // Handshake state machine
   // ----------------------------------------------------------------------
   reg next_ready_n;
   reg next_ack_n;

   always @* begin
      next_state   = state;
      next_ready_n = proc_ready_n;
      next_ack_n   = host_handshake_ack_n;
      case (state)
         ST_IDLE: begin
            next_ready_n = 1'b0;
            next_ack_n   = 1'b1;
            if (host_hit && proc_rw) begin
               next_state   = ST_RD_WAIT;
               next_ready_n = 1'b1;
            end else if (host_hit && !proc_rw) begin
               next_state   = ST_WR_WAIT;
               next_ready_n = 1'b1;
               next_ack_n   = 1'b0;
            end
         end
         ST_RD_WAIT: begin
            next_ack_n = !fifo_in_ready;
            if (fifo_out_valid) begin
               next_state   = ST_FINISH;
               next_ready_n = 1'b0;
               next_ack_n   = 1'b1;
            end
         end
         ST_WR_WAIT: begin
            if (strobe_rise) begin
               next_state   = ST_FINISH;
               next_ready_n = 1'b0;
               next_ack_n   = 1'b1;
            end
         end
         ST_FINISH: begin
            // A strobe that is already high again lets the next access
            // in after a single idle cycle, as back-to-back cycles need.
            next_ready_n = 1'b0;
            if (proc_strobe_n) begin
               next_state = ST_IDLE;
            end else begin
               next_state = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            next_ready_n = 1'b0;
            if (proc_strobe_n) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state   = ST_IDLE;
            next_ready_n = 1'b0;
            next_ack_n   = 1'b1;
         end
      endcase
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         state                <= ST_IDLE;
         proc_ready_n         <= `HP_READY_N_RST;
         host_handshake_ack_n <= `HP_ACK_N_RST;
         proc_rdata           <= {`HP_BYTE_W{1'b0}};
      end else begin
         state                <= next_state;
         proc_ready_n         <= next_ready_n;
         host_handshake_ack_n <= next_ack_n;
         if ((state == ST_RD_WAIT) && fifo_out_valid) begin
            proc_rdata <= fifo_out_data;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Data toward the host
   // ----------------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         host_data_out   <= {`HP_BYTE_W{1'b0}};
         host_nibble_out <= {`HP_NIBBLE_W{1'b0}};
         host_data_oe    <= 1'b0;
         xcvr_enable_n   <= 1'b1;
      end else begin
         if ((state == ST_IDLE) && host_hit && !proc_rw) begin
            host_data_out   <= proc_wdata;
            host_nibble_out <= proc_wdata[`HP_NIBBLE_W-1:0];
         end
         // Unidirectional ports read the nibble lines only.
         host_data_oe  <= (next_state == ST_WR_WAIT) && bidir_s;
         xcvr_enable_n <= !((next_state == ST_RD_WAIT) ||
                            (next_state == ST_WR_WAIT));
      end
   end

   // ----------------------------------------------------------------------
   // Attention interrupt, disconnect and processor reset
   // ----------------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         host_attention_irq    <= 1'b0;
         host_attention_irq_oe <= 1'b0;
         proc_ready_oe         <= 1'b0;
         proc_reset_n          <= `HP_PROC_RESET_RST;
      end else begin
         host_attention_irq    <= strobe_fall;
         host_attention_irq_oe <= !tri_s;
         proc_ready_oe         <= !tri_s;
         proc_reset_n          <= init_s;
      end
   end

   // ----------------------------------------------------------------------
   // Byte lane tracking within a word
   // ----------------------------------------------------------------------
   reg  first_word;
   wire lane_wrap;

   assign lane_wrap = (byte_lane == `HP_LANE_LAST) ||
                      (first_word && (byte_lane == `HP_BOOT_LANE_LAST));

   always @(posedge clk) begin
      if (sys_rst) begin
         byte_lane  <= 2'd0;
         first_word <= 1'b0;
      end else if (!init_s) begin
         byte_lane  <= 2'd0;
         first_word <= 1'b1;
      end else if ((state == ST_RD_WAIT) && fifo_out_valid) begin
         if (lane_wrap) begin
            byte_lane  <= 2'd0;
            first_word <= 1'b0;
         end else begin
            byte_lane <= byte_lane + 2'd1;
         end
      end else if ((state == ST_WR_WAIT) && strobe_rise) begin
         byte_lane <= (byte_lane == `HP_LANE_LAST) ? 2'd0
                      : byte_lane + 2'd1;
      end
   end

endmodule

`default_nettype wire

// [bench/printer_port_host_handshake_checker.sv]
`timescale 1ns/1ns
`default_nettype none

module printer_port_host_handshake_checker (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       proc_strobe_n,
   input wire logic       proc_rw,
   input wire logic [3:0] proc_addr_hi,
   input wire logic       proc_ready_n,
   input wire logic       proc_ready_oe,
   input wire logic       host_attention_irq,
   input wire logic       host_attention_irq_oe,
   input wire logic       aux_read_select,
   input wire logic       aux_write_select,
   input wire logic       ext_mem_select,
   input wire logic       xcvr_enable_n,
   input wire logic       host_byte_strobe_n,
   input wire logic       host_handshake_ack_n,
   input wire logic       tri_disconnect
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------------------------------
   // Window handshake steps
   // ----------------------------------------------------------------
   sequence s_take(logic rw);
      $fell(proc_strobe_n) && proc_addr_hi == 4'hf && proc_rw == rw;
   endsequence
   sequence s_rise;
      $rose(host_byte_strobe_n) && proc_ready_n && !host_handshake_ack_n;
   endsequence
   property p_rd_stall;
      s_take(1'b1) |=> proc_ready_n
         ##1 (proc_ready_n && !host_handshake_ack_n);
   endproperty
   a_rd_stall: assert property (p_rd_stall) else $error("read not held");
   property p_wr_stall;
      s_take(1'b0) |=> proc_ready_n && !host_handshake_ack_n;
   endproperty
   a_wr_stall: assert property (p_wr_stall) else $error("wr not held");
   property p_release;
      $fell(proc_ready_n) |->
         host_byte_strobe_n && $past(host_byte_strobe_n, 2);
   endproperty
   a_release: assert property (p_release) else $error("early end");
   property p_rise_done;
      s_rise |-> ##[2:6] !proc_ready_n;
   endproperty
   a_rise_done: assert property (p_rise_done) else $error("no release");
   property p_irq_pulse;
      host_attention_irq |=> !host_attention_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq long");
   property p_irq_cause;
      $fell(host_byte_strobe_n) |-> ##[2:5] host_attention_irq;
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq missing");
   property p_xcvr;
      !xcvr_enable_n |-> proc_ready_n;
   endproperty
   a_xcvr: assert property (p_xcvr) else $error("buffer on when idle");
   property p_aux_dec;
      !proc_strobe_n && proc_addr_hi == 4'h8 |=>
         aux_read_select == $past(proc_rw) &&
         aux_write_select != $past(proc_rw);
   endproperty
   a_aux_dec: assert property (p_aux_dec) else $error("aux decode");
   property p_idle_sel;
      proc_strobe_n |=> !(aux_read_select || aux_write_select || ext_mem_select);
   endproperty
   a_idle_sel: assert property (p_idle_sel) else $error("idle sel");
   property p_disc;
      tri_disconnect [*5] |-> !proc_ready_oe && !host_attention_irq_oe;
   endproperty
   a_disc: assert property (p_disc) else $error("still driving");
endmodule

`default_nettype wire

// [bench/pc_port_model.sv]
`timescale 1ns/1ns
`default_nettype none

module pc_port_model (
   input wire logic       clk,
   input wire logic       host_handshake_ack_n,
   input wire logic [7:0] host_data_out,
   input wire logic [3:0] host_nibble_out,
   input wire logic       bidir_mode,
   output logic           host_byte_strobe_n,
   output logic     [7:0] host_data_in
);
   int slow = 0;
   int miss = 0;

   initial begin
      host_byte_strobe_n = 1'b1;
      host_data_in = 8'h00;
   end

   // Waits for the ack level, then idles slow cycles like busy software.
   task automatic wait_ack(input logic lvl);
      int n;
      n = 0;
      while (host_handshake_ack_n !== lvl && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n == 200)
         miss++;
      repeat (slow) @(negedge clk);
   endtask

   task automatic send_byte(input logic [7:0] b);
      @(negedge clk);
      host_data_in = b;
      @(negedge clk);
      host_byte_strobe_n = 1'b0;
      repeat (3) @(negedge clk);
      wait_ack(1'b0);
      host_byte_strobe_n = 1'b1;
      wait_ack(1'b1);
      host_data_in = ~b;
   endtask

   task automatic recv(output logic [7:0] b);
      if (bidir_mode)
         host_data_in = ~host_data_in;
      wait_ack(1'b0);
      host_byte_strobe_n = 1'b0;
      repeat (3) @(negedge clk);
      b = bidir_mode ? host_data_out : {4'h0, host_nibble_out};
      host_byte_strobe_n = 1'b1;
      wait_ack(1'b1);
   endtask
endmodule

`default_nettype wire

// [bench/printer_port_host_handshake_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module printer_port_host_handshake_tb_top;
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       proc_strobe_n = 1'b1;
   logic       proc_rw = 1'b1;
   logic [3:0] proc_addr_hi = 4'h0;
   logic [7:0] proc_wdata = 8'h00;
   logic       host_init_n = 1'b1;
   logic       tri_disconnect = 1'b0;
   logic       bidir_mode = 1'b1;
   logic       led_select_a = 1'b0;
   logic [1:0] led_color = 2'b00;
   wire  [7:0] proc_rdata, host_data_in, host_data_out;
   wire  [3:0] host_nibble_out;
   wire  [1:0] byte_lane;
   wire        proc_ready_n, proc_ready_oe, host_attention_irq;
   wire        host_attention_irq_oe, proc_reset_n, aux_read_select;
   wire        aux_write_select, aux_io_select, ext_mem_select;
   wire        boot_select, xcvr_enable_n, host_byte_strobe_n;
   wire        host_data_oe, host_handshake_ack_n;
   int         fails = 0;
   int         checks_done = 0;

   always #2 clk = ~clk;

   printer_port_host_handshake uut (
      .clk, .sys_rst, .proc_strobe_n, .proc_rw, .proc_addr_hi, .proc_wdata,
      .proc_rdata, .proc_ready_n, .proc_ready_oe, .host_attention_irq,
      .host_attention_irq_oe, .proc_reset_n, .byte_lane, .aux_read_select,
      .aux_write_select, .aux_io_select, .ext_mem_select, .boot_select,
      .xcvr_enable_n, .host_byte_strobe_n, .host_init_n, .host_data_in,
      .host_data_out, .host_data_oe, .host_nibble_out, .host_handshake_ack_n,
      .tri_disconnect, .bidir_mode, .led_select_a, .led_color
   );

   pc_port_model host (
      .clk, .host_handshake_ack_n, .host_data_out, .host_nibble_out,
      .bidir_mode, .host_byte_strobe_n, .host_data_in
   );

   // ----------------------------------------------------------------
   // Checking and bus helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, exp, input string m);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic print_verdict();
      if (fails == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   function automatic logic [4:0] exp_sel(input logic [3:0] a, input logic w);
      exp_sel = {a == 4'h8 && w, a == 4'h8 && !w, a == 4'h8, a == 4'h0,
                 a == 4'h4};
   endfunction

   // Holds the bus request until the ready line reports completion.
   task automatic proc_acc(input logic rw, input logic [3:0] a,
                           input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      @(negedge clk);
      proc_strobe_n = 1'b0;
      proc_rw = rw;
      proc_addr_hi = a;
      proc_wdata = wd;
      @(negedge clk);
      while (proc_ready_n !== 1'b0 && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk(n < 300, 1, "ready");
      rd = proc_rdata;
      proc_strobe_n = 1'b1;
   endtask

   // Moves one word in pieces, low piece first; nb of 8 means nibbles.
   task automatic xfer(input logic rd, input int nb, input logic [31:0] w,
                       output logic [31:0] got);
      logic [7:0] p, q, r;
      int s;
      got = 32'h0;
      s = (nb == 8) ? 4 : 8;
      for (int b = 0; b < nb; b++) begin
         host.slow = $urandom % 8;
         p = 8'(w >> (s * b));
         if (s == 4)
            p[7:4] = 4'($urandom);
         fork
            proc_acc(rd, 4'hf, p, r);
            if (rd)
               host.send_byte(p);
            else
               host.recv(q);
            if (!rd) begin
               wait (!host_handshake_ack_n);
               @(negedge clk);
               chk(host_data_oe, bidir_mode, "data drive");
            end
         join
         chk(host_data_oe, 0, "data idle");
         got = got | ((32'(rd ? r : q) & ((32'h1 << s) - 1)) << (s * b));
         chk(byte_lane, (b + 1) % (nb == 2 ? 2 : 4), "lane");
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] w, got;
      logic [7:0]  r;
      int          k;
      k = $urandom(32'h424595d4);
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      chk({proc_ready_n, host_handshake_ack_n, xcvr_enable_n, proc_reset_n},
          4'b0110, "reset state");
      repeat (4) @(negedge clk);
      host_init_n = 1'b0;
      repeat (5) @(negedge clk);
      chk(proc_reset_n, 0, "reset held");
      host_init_n = 1'b1;
      repeat (5) @(negedge clk);
      chk(proc_reset_n, 1, "reset freed");
      for (int i = 0; i < 30; i++) begin
         proc_acc(i[0], i[4:1], 8'h00, r);
         chk({aux_read_select, aux_write_select, aux_io_select,
              ext_mem_select, boot_select},
             exp_sel(i[4:1], i[0]), "decode");
      end
      w = $urandom;
      xfer(1'b1, 2, w, got);
      chk(got, w & 32'hffff, "boot word");
      for (int m = 0; m < 6; m++) begin
         w = (m == 0) ? 32'hff00_00ff : $urandom;
         bidir_mode = (m < 4);
         repeat (4) @(negedge clk);
         xfer(m < 2, (m >= 4) ? 8 : 4, w, got);
         chk(got, w, "word");
      end
      tri_disconnect = 1'b1;
      repeat (6) @(negedge clk);
      chk({proc_ready_oe, host_attention_irq_oe}, 0, "float");
      tri_disconnect = 1'b0;
      repeat (6) @(negedge clk);
      chk({proc_ready_oe, host_attention_irq_oe}, 3, "drive");
      led_select_a = 1'b1;
      for (int c = 0; c < 4; c++) begin
         led_color = c[1:0];
         repeat (6) @(negedge clk);
         chk({boot_select, aux_io_select}, c, "led");
      end
      led_select_a = 1'b0;
      chk(host.miss, 0, "host wait");
      print_verdict();
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      print_verdict();
   end
endmodule

bind printer_port_host_handshake printer_port_host_handshake_checker chk_i (
   .clk, .sys_rst, .proc_strobe_n, .proc_rw, .proc_addr_hi, .proc_ready_n,
   .proc_ready_oe, .host_attention_irq, .host_attention_irq_oe,
   .aux_read_select, .aux_write_select, .ext_mem_select, .xcvr_enable_n,
   .host_byte_strobe_n, .host_handshake_ack_n, .tri_disconnect
);

`default_nettype wire
